// File: tb/tb_top.sv
// Self-checking bench for the endpoint transfer block
`timescale 1ns/1ps
module tb_top;
    logic REF_CLK = 0, RST = 1, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
    logic USB_BUS_RESET = 0, SIE_RX_DONE = 0, SIE_TX_DONE = 0, SIE_SETUP = 0, SIE_RX_SHORT = 0;
    logic SIE_EOP = 0, SIE_RX_WE = 0, AWREADY, WREADY, BVALID, ARREADY, RVALID, SIE_TX_READY;
    logic TRANSFER_REQUEST_OUT, TRANSFER_ACKNOWLEDGE_IN, TRANSFER_END_INPUT, gs;
    logic RD_STROBE_N, WR_STROBE_N, DATA_OE_N;
    logic [7:0] AWADDR = 0, ARADDR = 0, SIE_RX_DATA = 0, DATA_IN, DATA_OUT, gb, pkt[8];
    logic [3:0] WSTRB = 4'hf, SIE_EP = 0;
    logic [1:0] BRESP, RRESP, rr;
    logic [31:0] WDATA = 0, RDATA, rv;
    int bad_count = 0, n_tests = 0, i, n, len, got, ep;
    ude_top i_dut (.*);
    ude_dma_model i_dma (.clk(REF_CLK), .req(TRANSFER_REQUEST_OUT), .dout(DATA_OUT),
        .ack(TRANSFER_ACKNOWLEDGE_IN), .rd_n(RD_STROBE_N), .wr_n(WR_STROBE_N),
        .transfer_end_input(TRANSFER_END_INPUT), .din(DATA_IN), .got_stb(gs), .got_byte(gb));
    initial forever #10 REF_CLK = ~REF_CLK;
    task complete_run;
        $display("tests %0d bad %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge REF_CLK);
        AWADDR <= a; WDATA <= d; AWVALID <= 1; WVALID <= 1; BREADY <= 1;
        for (k = 0; k < 200; k++) begin
            @(posedge REF_CLK);
            if (AWREADY) AWVALID <= 0;
            if (WREADY) WVALID <= 0;
            if (BVALID) break;
        end
        BREADY <= 0;
        if (k == 200) begin bad_count++; complete_run; end
    endtask
    task automatic rd(input logic [7:0] a);
        int k;
        @(posedge REF_CLK);
        ARADDR <= a; ARVALID <= 1; RREADY <= 1;
        for (k = 0; k < 200; k++) begin
            @(posedge REF_CLK);
            if (ARREADY) ARVALID <= 0;
            if (RVALID) break;
        end
        rv = RDATA; rr = RRESP; RREADY <= 0;
        if (k == 200) begin bad_count++; complete_run; end
    endtask
    initial begin
        void'($urandom(21));
        repeat (10) @(posedge REF_CLK);
        RST <= 0;
        rd(8'h18); chk("xfer_setup", 0, rv);
        rd(8'h20); chk("hw_setup", 0, rv);
        wr(8'h20, 6);
        rd(8'h40); chk("unmapped", 2, rr);
        $display("reset test done");
        repeat (2) begin
            ep = $urandom_range(15, 2); len = $urandom_range(8, 2); n = $urandom_range(len, 1);
            wr(8'h04, ep); wr(8'h0c, 1);
            @(posedge REF_CLK); SIE_EP <= ep[3:0];
            for (i = 0; i < len; i++) begin
                pkt[i] = $urandom; SIE_RX_DATA <= pkt[i]; SIE_RX_WE <= 1; @(posedge REF_CLK);
            end
            SIE_RX_WE <= 0; SIE_RX_DONE <= 1; @(posedge REF_CLK); SIE_RX_DONE <= 0;
            rd(8'h00); chk("flag_set", 1, rv[ep]);
            rd(8'h08); chk("status", {1'b1, ep[3:0]}, rv[4:0]);
            rd(8'h00); chk("flag_clear", 0, rv[ep]);
            wr(8'h1c, n); wr(8'h18, 32'h30 | ep);
            got = 0;
            repeat (600) begin
                @(posedge REF_CLK);
                if (gs) begin chk("dma_byte", pkt[got % 8], gb); got++; end
            end
            chk("byte_count", n, got);
            chk("req_idle", 0, TRANSFER_REQUEST_OUT);
            rd(8'h18); chk("run_cleared", 0, rv[4]);
            wr(8'h04, ep); rd(8'h08); chk("buf_cleared", 0, rv[4]);
            $display("transfer test done");
        end
        for (i = 0; i < 2; i++) begin
            wr(8'h18, 32'h10 | i); repeat (20) @(posedge REF_CLK);
            chk("ctrl_no_req", 0, TRANSFER_REQUEST_OUT);
        end
        $display("control index test done");
        complete_run;
    end
endmodule

// File: tb/ude_checker.sv
// Port-level assertions for the endpoint transfer block
`timescale 1ns/1ps
module ude_checker (
    // Clock, reset and bus handshakes
    input wire logic        REF_CLK, RST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY,
    input wire logic        ARVALID, ARREADY, RVALID, RREADY,
    input wire logic [7:0]  ARADDR,
    input wire logic [31:0] RDATA,
    input wire logic [1:0]  RRESP,
    // Fly-by pins
    input wire logic        RD_STROBE_N, DATA_OE_N
);
    logic [3:0] since_rd_r;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    // Cycles since read strobe was low
    always_ff @(posedge REF_CLK)
        since_rd_r <= RST ? 4'hf : !RD_STROBE_N ? 4'h0 : since_rd_r + {3'h0, since_rd_r != 4'hf};
    property p_oe_rst; $fell(RST) |-> DATA_OE_N; endproperty
    a_oe_rst: assert property (p_oe_rst) else $error("data driven after reset");
    property p_oe_strobe; !DATA_OE_N |-> since_rd_r < 4'h8; endproperty
    a_oe_strobe: assert property (p_oe_strobe) else $error("data driven without strobe");
    property p_rd_answer; ARVALID && ARREADY |=> RVALID; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("late read answer");
    property p_rvalid_hold; RVALID && !RREADY |=> RVALID && $stable(RDATA); endproperty
    a_rvalid_hold: assert property (p_rvalid_hold) else $error("read answer dropped");
    property p_bvalid_hold; BVALID && !BREADY |=> BVALID; endproperty
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("write answer dropped");
    property p_wr_answer; AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID; endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("late write answer");
    property p_unmapped; ARVALID && ARREADY && ARADDR > 8'h20 |=> RRESP == 2'b10; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    property p_mapped;
        ARVALID && ARREADY && ARADDR <= 8'h20 && ARADDR[1:0] == 2'b00 && ARADDR != 8'h10
            |=> RRESP == 2'b00;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped read refused");
endmodule
bind ude_top ude_checker i_chk (.*);

// File: tb/ude_dma_model.sv
// Fly-by transfer controller model, read direction
`timescale 1ns/1ps
module ude_dma_model (
    input  wire logic       clk, req,
    input  wire logic [7:0] dout,
    output logic            ack, rd_n, wr_n, transfer_end_input, got_stb,
    output logic [7:0]      din, got_byte
);
    initial begin
        ack = 0; rd_n = 1; wr_n = 1; transfer_end_input = 0; got_stb = 0; got_byte = 0;
        forever begin
            @(posedge clk);
            if (req) begin
                repeat ($urandom_range(4, 1)) @(posedge clk);
                ack <= 1;
                repeat (2) @(posedge clk);
                rd_n <= 0;
                repeat (6) @(posedge clk);
                got_byte <= dout; got_stb <= 1; rd_n <= 1;
                @(posedge clk);
                got_stb <= 0; ack <= 0;
                repeat (6) @(posedge clk);
            end
        end
    end
    // Released data lines toggle
    initial din = 8'h5a;
    always @(posedge clk) din <= ~din;
endmodule

// File: verilog/ude_axil.v
// AXI4-Lite slave front end: holds one write and one read, single-cycle strobes
`timescale 1ns/1ps
module ude_axil (
    // Clock and reset
    input  wire        REF_CLK,
    input  wire        RST,
    // AXI4-Lite
    input  wire [7:0]  awaddr,
    input  wire        awvalid,
    output wire        awready,
    input  wire [31:0] wdata,
    input  wire [3:0]  wstrb,
    input  wire        wvalid,
    output wire        wready,
    output reg  [1:0]  bresp,
    output reg         bvalid,
    input  wire        bready,
    input  wire [7:0]  araddr,
    input  wire        arvalid,
    output wire        arready,
    output reg  [31:0] rdata,
    output reg  [1:0]  rresp,
    output reg         rvalid,
    input  wire        rready,
    // Register side
    output wire        wr_stb,
    output wire [7:0]  wr_addr,
    output wire [31:0] wr_data,
    output wire [3:0]  wr_be,
    input  wire        wr_ok,
    output wire        rd_stb,
    output wire [7:0]  rd_addr,
    input  wire [31:0] rd_data,
    input  wire        rd_ok
);
    reg        aw_full_r;
    reg        w_full_r;
    reg [7:0]  aw_r;
    reg [31:0] wd_r;
    reg [3:0]  ws_r;

    assign awready = !aw_full_r && !bvalid;
    assign wready  = !w_full_r && !bvalid;
    assign arready = !rvalid;
    assign wr_stb  = aw_full_r && w_full_r && !bvalid;
    assign wr_addr = aw_r;
    assign wr_data = wd_r;
    assign wr_be   = ws_r;
    assign rd_stb  = arvalid && !rvalid;
    assign rd_addr = araddr;

    always @(posedge REF_CLK) begin
        if (RST) begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            aw_r      <= 8'h00;
            wd_r      <= 32'h0;
            ws_r      <= 4'h0;
            bvalid    <= 1'b0;
            bresp     <= 2'h0;
            rvalid    <= 1'b0;
            rresp     <= 2'h0;
            rdata     <= 32'h0;
        end else begin
            if (awvalid && awready) begin
                aw_full_r <= 1'b1;
                aw_r      <= {awaddr[7:2], 2'h0};
            end
            if (wvalid && wready) begin
                w_full_r <= 1'b1;
                wd_r     <= wdata;
                ws_r     <= wstrb;
            end
            if (wr_stb) begin
                aw_full_r <= 1'b0;
                w_full_r  <= 1'b0;
                bvalid    <= 1'b1;
                bresp     <= wr_ok ? 2'h0 : 2'h2;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
            if (rd_stb) begin
                rvalid <= 1'b1;
                rdata  <= rd_data;
                rresp  <= rd_ok ? 2'h0 : 2'h2;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule

// File: verilog/ude_regs.vh
// Register offsets, command codes, field positions, reset values, burst length and buffer depth for the endpoint DMA block
`ifndef UDE_REGS_VH
`define UDE_REGS_VH

// ==========================================================================
// Register byte offsets
`define UDE_OFF_IRQ        8'h00
`define UDE_OFF_STAT_SEL   8'h04
`define UDE_OFF_STATUS     8'h08
`define UDE_OFF_EPCFG      8'h0c
`define UDE_OFF_BUFCMD     8'h10
`define UDE_OFF_BUFDATA    8'h14
`define UDE_OFF_XFER_SETUP 8'h18
`define UDE_OFF_XFER_COUNT 8'h1c
`define UDE_OFF_HW_SETUP   8'h20

// ==========================================================================
// Buffer command codes
`define UDE_CMD_CLEAR      3'h1
`define UDE_CMD_VALIDATE   3'h2
`define UDE_CMD_SETUP_ACK  3'h3
`define UDE_CMD_SELECT     3'h4

// ==========================================================================
// Transfer engine setup fields
`define UDE_XS_IDX_LO      0
`define UDE_XS_IDX_HI      3
`define UDE_XS_RUN         4
`define UDE_XS_CNT_TERM    5
`define UDE_XS_SHORT_TERM  6
`define UDE_XS_BURST       7
`define UDE_XS_RESET       8'h00

// ==========================================================================
// Hardware setup fields
`define UDE_HW_ACK_ONLY    0
`define UDE_HW_REQ_POL     1
`define UDE_HW_ACK_POL     2
`define UDE_HW_RESET       3'h0

// ==========================================================================
// Endpoint setup fields: enable, direction, isochronous
`define UDE_EC_EN          0
`define UDE_EC_DIR         1
`define UDE_EC_ISO         2
`define UDE_EC_RESET       3'h0

// ==========================================================================
// Burst length in bytes and buffer depth
`define UDE_BURST_LEN      5'h10
`define UDE_BUF_DEPTH      64

`endif

// File: verilog/ude_sync.v
// Two flip-flop synchroniser for one pin input
`timescale 1ns/1ps
module ude_sync (
    // Clock and reset
    input  wire REF_CLK,
    input  wire RST,
    // Pin side
    input  wire d_in,
    // Clock domain side
    output reg  q_out
);
    reg meta_r;

    always @(posedge REF_CLK) begin
        if (RST) begin
            meta_r <= 1'b0;
            q_out  <= 1'b0;
        end else begin
            meta_r <= d_in;
            q_out  <= meta_r;
        end
    end
endmodule

// File: verilog/ude_top.v
// Endpoint buffer access and fly-by transfer engine of a USB device controller
// Overview of operation
// R1: Packet sent or received on an endpoint sets its event flag.
// R2: Reading endpoint status clears its event flag; status shows buffer state.
// R3: Receive buffer read gives length then data; clear command frees buffer.
// R4: Transmit buffer written with length and data; validate allows sending.
// R5: Set-up packet flushes control IN, blocks validate and clear on control.
// R6: Set-up acknowledge to both control endpoints re-enables validate and clear.
// R7: Single-cycle transfers and bursts of up to 16 bytes.
// R8: Request and acknowledge polarities are programmable.
// R9: Four-bit index codes 0010 to 1111 select endpoints 2 to 15.
// R10: Direction follows endpoint direction bit: OUT read, IN written.
// R11: Acknowledge forces bus accesses onto the transfer-selected endpoint.
// R12: Fly-by handshake mode used when acknowledge-only bit is clear.
// R13: Device drives request; controller drives acknowledge, end input, strobes.
// R14: Acknowledged read drives endpoint data while read strobe is asserted.
// R15: Request drops after each byte in single mode, after burst otherwise.
// R16: Acknowledge released ends the cycle; device stops driving data.
// R17: Bulk transfer ends on count, short OUT packet, or enable clear.
// R18: Setting enable loads counter from byte count; completion ends transfer.
// R19: Short packet stops transfer only after all its bytes moved.
// R20: Bulk IN with short termination ends at zero count mid-buffer.
// R21: Clearing enable stops the transfer with no interrupt.
// R22: Isochronous transfer ends on count, end-of-packet, or enable clear.
// R23: Receive endpoint requests while enabled and a buffer is full.
// R24: Termination clears the endpoint buffer and disables the engine; an IN endpoint buffer is set full (validated) instead of cleared.
// R25: Reset disables configurable endpoints, clears setup; control stays enabled.
// R26: Index codes 0000 and 0001 never raise a request.
// R27: External end input terminates like an internal end condition.
`timescale 1ns/1ps
`include "ude_regs.vh"
module ude_top (
    // Clock and reset
    input  wire        REF_CLK,
    input  wire        RST,
    // AXI4-Lite
    input  wire [7:0]  AWADDR,
    input  wire        AWVALID,
    output wire        AWREADY,
    input  wire [31:0] WDATA,
    input  wire [3:0]  WSTRB,
    input  wire        WVALID,
    output wire        WREADY,
    output wire [1:0]  BRESP,
    output wire        BVALID,
    input  wire        BREADY,
    input  wire [7:0]  ARADDR,
    input  wire        ARVALID,
    output wire        ARREADY,
    output wire [31:0] RDATA,
    output wire [1:0]  RRESP,
    output wire        RVALID,
    input  wire        RREADY,
    // Serial engine events
    input  wire        USB_BUS_RESET,
    input  wire        SIE_RX_DONE,
    input  wire        SIE_TX_DONE,
    input  wire [3:0]  SIE_EP,
    input  wire        SIE_SETUP,
    input  wire        SIE_RX_SHORT,
    input  wire        SIE_EOP,
    input  wire [7:0]  SIE_RX_DATA,
    input  wire        SIE_RX_WE,
    output wire        SIE_TX_READY,
    // Fly-by transfer pins
    output wire        TRANSFER_REQUEST_OUT,
    input  wire        TRANSFER_ACKNOWLEDGE_IN,
    input  wire        TRANSFER_END_INPUT,
    input  wire        RD_STROBE_N,
    input  wire        WR_STROBE_N,
    input  wire [7:0]  DATA_IN,
    output wire [7:0]  DATA_OUT,
    output wire        DATA_OE_N
);
    // ======================================================================
    // Pin synchronisers
    wire ack_s;
    wire eot_s;
    wire rd_s;
    wire wr_s;
    // R13 controller pins
    ude_sync u_sack (.REF_CLK(REF_CLK), .RST(RST), .d_in(TRANSFER_ACKNOWLEDGE_IN), .q_out(ack_s));
    ude_sync u_seot (.REF_CLK(REF_CLK), .RST(RST), .d_in(TRANSFER_END_INPUT), .q_out(eot_s));
    ude_sync u_srd  (.REF_CLK(REF_CLK), .RST(RST), .d_in(~RD_STROBE_N), .q_out(rd_s));
    ude_sync u_swr  (.REF_CLK(REF_CLK), .RST(RST), .d_in(~WR_STROBE_N), .q_out(wr_s));

    // ======================================================================
    // Bus slave
    wire        wr_stb;
    wire [7:0]  wr_addr;
    wire [31:0] wr_data;
    wire [3:0]  wr_be;
    wire        rd_stb;
    wire [7:0]  rd_addr;
    reg  [31:0] rd_mux;
    reg         rd_hit;
    reg         wr_hit;
    ude_axil u_bus (
        .REF_CLK(REF_CLK), .RST(RST),
        .awaddr(AWADDR), .awvalid(AWVALID), .awready(AWREADY),
        .wdata(WDATA), .wstrb(WSTRB), .wvalid(WVALID), .wready(WREADY),
        .bresp(BRESP), .bvalid(BVALID), .bready(BREADY),
        .araddr(ARADDR), .arvalid(ARVALID), .arready(ARREADY),
        .rdata(RDATA), .rresp(RRESP), .rvalid(RVALID), .rready(RREADY),
        .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data), .wr_be(wr_be),
        .wr_ok(wr_hit), .rd_stb(rd_stb), .rd_addr(rd_addr),
        .rd_data(rd_mux), .rd_ok(rd_hit)
    );

    // ======================================================================
    // State
    reg [15:0] event_flag_r;
    reg [3:0]  pio_sel_r;
    reg [2:0]  ep_setup_r [0:15];
    reg [15:0] buf_full_r;
    reg [6:0]  buf_len_r  [0:15];
    reg [6:0]  rd_ptr_r   [0:15];
    reg [15:0] short_r;
    reg [7:0]  xs_r;
    reg [2:0]  hw_r;
    reg [15:0] byte_count_r;
    reg [15:0] cnt_r;
    reg [4:0]  burst_cnt_r;
    reg        req_r;
    reg        setup_lock_r;
    reg [1:0]  setup_ack_r;
    reg        rd_d_r;
    reg        wr_d_r;
    reg [7:0]  dout_r;
    reg        doe_r;
    reg [7:0]  mem_r [0:`UDE_BUF_DEPTH-1];

    // R9 index code to endpoint slot
    function [3:0] idx_to_ep;
        input [3:0] code;
        begin
            idx_to_ep = (code < 4'h2) ? 4'h0 : code;
        end
    endfunction

    wire       run       = xs_r[`UDE_XS_RUN];
    wire [3:0] xfer_ep   = idx_to_ep(xs_r[`UDE_XS_IDX_HI:`UDE_XS_IDX_LO]);
    // R10 direction from setup
    wire       ep_in     = ep_setup_r[xfer_ep][`UDE_EC_DIR];
    wire       ep_iso    = ep_setup_r[xfer_ep][`UDE_EC_ISO];
    wire       ack_act   = ack_s ^ hw_r[`UDE_HW_ACK_POL] ^ 1'b1;
    wire       flyby     = !hw_r[`UDE_HW_ACK_ONLY];
    // R11 transfer endpoint overrides
    wire [3:0] bus_ep    = ack_act ? xfer_ep : pio_sel_r;
    wire [6:0] cur_ptr   = rd_ptr_r[xfer_ep];
    wire       rd_edge   = rd_s && !rd_d_r;
    wire       wr_edge   = wr_s && !wr_d_r;
    wire       xfer_ok   = run && flyby && (xfer_ep != 4'h0) && ack_act;
    wire       rd_beat   = xfer_ok && !ep_in && rd_edge;
    wire       wr_beat   = xfer_ok && ep_in && wr_edge;
    wire       beat      = rd_beat || wr_beat;
    wire       last_byte = rd_beat && (cur_ptr + 7'h1 >= buf_len_r[xfer_ep]);
    // R17 bulk end conditions
    wire       cnt_done  = xs_r[`UDE_XS_CNT_TERM] && beat && (cnt_r == 16'h1);
    // R19 short after last byte
    wire       short_end = !ep_iso && xs_r[`UDE_XS_SHORT_TERM] && !ep_in
                           && short_r[xfer_ep] && last_byte;
    // R20 short IN at zero count
    wire       in_short  = !ep_iso && xs_r[`UDE_XS_SHORT_TERM] && wr_beat
                           && (cnt_r == 16'h1);
    // R22 isochronous end of packet
    wire       iso_end   = ep_iso && run && SIE_EOP && (SIE_EP == xfer_ep);
    // R27 external end input
    wire       terminate = run && (cnt_done || short_end || in_short || iso_end
                           || (eot_s && ack_act));
    wire       sel_wr    = wr_stb && wr_be[0];

    // ======================================================================
    // Request logic
    // R23 request on full buffer
    // R26 control codes never request
    wire want = run && flyby && (xfer_ep != 4'h0) && !terminate
                && (ep_in ? !buf_full_r[xfer_ep] : buf_full_r[xfer_ep]);
    // R8 request polarity
    assign TRANSFER_REQUEST_OUT = req_r ^ hw_r[`UDE_HW_REQ_POL] ^ 1'b1;
    // R14 drive data during read
    assign DATA_OUT     = dout_r;
    assign DATA_OE_N    = !doe_r;
    assign SIE_TX_READY = buf_full_r[SIE_EP] && ep_setup_r[SIE_EP][`UDE_EC_DIR];

    // ======================================================================
    // Read mux
    always @* begin
        rd_hit = 1'b1;
        rd_mux = 32'h0;
        case (rd_addr)
            `UDE_OFF_IRQ:        rd_mux = {16'h0, event_flag_r};
            `UDE_OFF_STAT_SEL:   rd_mux = {28'h0, pio_sel_r};
            `UDE_OFF_STATUS:     rd_mux = {24'h0, short_r[bus_ep], setup_lock_r,
                                           buf_len_r[bus_ep][5:0] == 6'h0, buf_full_r[bus_ep],
                                           bus_ep};
            `UDE_OFF_EPCFG:      rd_mux = {29'h0, ep_setup_r[pio_sel_r]};
            `UDE_OFF_BUFDATA:    rd_mux = {17'h0, buf_len_r[bus_ep], mem_r[rd_ptr_r[bus_ep][5:0]]};
            `UDE_OFF_XFER_SETUP: rd_mux = {24'h0, xs_r};
            `UDE_OFF_XFER_COUNT: rd_mux = {cnt_r, byte_count_r};
            `UDE_OFF_HW_SETUP:   rd_mux = {29'h0, hw_r};
            default:             rd_hit = 1'b0;
        endcase
    end

    always @* begin
        case (wr_addr)
            `UDE_OFF_STAT_SEL, `UDE_OFF_EPCFG, `UDE_OFF_BUFCMD, `UDE_OFF_BUFDATA,
            `UDE_OFF_XFER_SETUP, `UDE_OFF_XFER_COUNT, `UDE_OFF_HW_SETUP: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // ======================================================================
    // Per-endpoint buffer state
    wire       cmd_wr   = sel_wr && (wr_addr == `UDE_OFF_BUFCMD);
    wire [2:0] cmd      = wr_data[2:0];
    wire       ctl_ep   = (pio_sel_r < 4'h2);
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_ep
            wire hit_pio = (bus_ep == g);
            always @(posedge REF_CLK) begin
                // R25 reset clears endpoint setup
                if (RST || USB_BUS_RESET) begin
                    ep_setup_r[g] <= (g < 2) ? 3'h1 | ((g == 1) ? 3'h2 : 3'h0)
                                             : `UDE_EC_RESET;
                    buf_full_r[g] <= 1'b0;
                    buf_len_r[g]  <= 7'h0;
                    rd_ptr_r[g]   <= 7'h0;
                    short_r[g]    <= 1'b0;
                    event_flag_r[g] <= 1'b0;
                end else begin
                    if (sel_wr && wr_addr == `UDE_OFF_EPCFG && pio_sel_r == g && g > 1)
                        ep_setup_r[g] <= wr_data[2:0];
                    // R3 receive fill from engine
                    if (SIE_RX_WE && SIE_EP == g && !buf_full_r[g])
                        buf_len_r[g] <= buf_len_r[g] + 7'h1;
                    if (SIE_RX_DONE && SIE_EP == g) begin
                        buf_full_r[g] <= 1'b1;
                        short_r[g]    <= SIE_RX_SHORT;
                        rd_ptr_r[g]   <= 7'h0;
                    end
                    if (hit_pio && sel_wr && wr_addr == `UDE_OFF_BUFDATA)
                        buf_len_r[g] <= buf_len_r[g] + 7'h1;
                    if (hit_pio && rd_stb && rd_addr == `UDE_OFF_BUFDATA)
                        rd_ptr_r[g] <= rd_ptr_r[g] + 7'h1;
                    if (xfer_ep == g && rd_beat)
                        rd_ptr_r[g] <= rd_ptr_r[g] + 7'h1;
                    if (xfer_ep == g && wr_beat)
                        buf_len_r[g] <= buf_len_r[g] + 7'h1;
                    // R3 clear command frees buffer
                    // R4 validate arms transmit
                    // R5 locked while set-up pending
                    if (cmd_wr && pio_sel_r == g && !(ctl_ep && setup_lock_r)) begin
                        if (cmd == `UDE_CMD_CLEAR) begin
                            buf_full_r[g] <= 1'b0;
                            buf_len_r[g]  <= 7'h0;
                        end else if (cmd == `UDE_CMD_VALIDATE) begin
                            buf_full_r[g] <= 1'b1;
                        end
                    end
                    if (SIE_TX_DONE && SIE_EP == g) begin
                        buf_full_r[g] <= 1'b0;
                        buf_len_r[g]  <= 7'h0;
                    end
                    // R5 flush control IN
                    if (SIE_SETUP && g == 1) begin
                        buf_full_r[g] <= 1'b0;
                        buf_len_r[g]  <= 7'h0;
                    end
                    // R24 clear OUT buffer on end, set IN buffer full
                    if (terminate && xfer_ep == g && !ep_in) begin
                        buf_full_r[g] <= 1'b0;
                        buf_len_r[g]  <= 7'h0;
                    end
                    if (terminate && xfer_ep == g && ep_in)
                        buf_full_r[g] <= 1'b1;
                    // R1 set event flag
                    if ((SIE_RX_DONE || SIE_TX_DONE) && SIE_EP == g)
                        event_flag_r[g] <= 1'b1;
                    // R2 status read clears flag, set wins
                    else if (rd_stb && rd_addr == `UDE_OFF_STATUS && bus_ep == g)
                        event_flag_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // ======================================================================
    // Shared buffer storage, data bytes
    always @(posedge REF_CLK) begin
        if (SIE_RX_WE)
            mem_r[buf_len_r[SIE_EP][5:0]] <= SIE_RX_DATA;
        else if (wr_beat)
            mem_r[buf_len_r[xfer_ep][5:0]] <= DATA_IN;
        else if (sel_wr && wr_addr == `UDE_OFF_BUFDATA)
            mem_r[buf_len_r[bus_ep][5:0]] <= wr_data[7:0];
    end

    // ======================================================================
    // Control, set-up lock and transfer engine
    always @(posedge REF_CLK) begin
        if (RST || USB_BUS_RESET) begin
            pio_sel_r    <= 4'h0;
            xs_r         <= `UDE_XS_RESET;
            hw_r         <= `UDE_HW_RESET;
            byte_count_r <= 16'h0;
            cnt_r        <= 16'h0;
            burst_cnt_r  <= 5'h0;
            req_r        <= 1'b0;
            setup_lock_r <= 1'b0;
            setup_ack_r  <= 2'h0;
            rd_d_r       <= 1'b0;
            wr_d_r       <= 1'b0;
            dout_r       <= 8'h00;
            doe_r        <= 1'b0;
        end else begin
            rd_d_r <= rd_s;
            wr_d_r <= wr_s;
            if (sel_wr && wr_addr == `UDE_OFF_STAT_SEL)
                pio_sel_r <= wr_data[3:0];
            if (sel_wr && wr_addr == `UDE_OFF_HW_SETUP)
                hw_r <= wr_data[2:0];
            if (sel_wr && wr_addr == `UDE_OFF_XFER_COUNT)
                byte_count_r <= wr_data[15:0];
            // R6 acknowledge both control endpoints
            if (SIE_SETUP) begin
                setup_lock_r <= 1'b1;
                setup_ack_r  <= 2'h0;
            end else if (cmd_wr && cmd == `UDE_CMD_SETUP_ACK && ctl_ep) begin
                setup_ack_r[pio_sel_r[0]] <= 1'b1;
                if (setup_ack_r[~pio_sel_r[0]])
                    setup_lock_r <= 1'b0;
            end
            // R18 load counter on enable
            // R21 clear stops silently
            if (sel_wr && wr_addr == `UDE_OFF_XFER_SETUP) begin
                xs_r <= wr_data[7:0];
                if (wr_data[`UDE_XS_RUN] && !run)
                    cnt_r <= byte_count_r;
            end else if (terminate) begin
                xs_r[`UDE_XS_RUN] <= 1'b0;
            end else if (beat && cnt_r != 16'h0) begin
                cnt_r <= cnt_r - 16'h1;
            end
            // R15 drop request after byte or burst
            // R7 burst of up to 16
            if (!run || terminate) begin
                req_r       <= 1'b0;
                burst_cnt_r <= 5'h0;
            end else if (beat) begin
                if (!xs_r[`UDE_XS_BURST] || burst_cnt_r + 5'h1 >= `UDE_BURST_LEN) begin
                    req_r       <= 1'b0;
                    burst_cnt_r <= 5'h0;
                end else begin
                    burst_cnt_r <= burst_cnt_r + 5'h1;
                end
            end else if (!ack_act) begin
                // R12 fly-by request only
                req_r <= want;
            end
            // R14 present byte on read
            // R16 stop driving when released
            if (rd_beat) begin
                doe_r  <= 1'b1;
                dout_r <= mem_r[cur_ptr[5:0]];
            end else if (!ack_act || !rd_s) begin
                doe_r <= 1'b0;
            end
        end
    end
endmodule
